// ===== core/wdt_pkg.sv
// Constants, register map and field layout for the watchdog timer unit.
// Assumes a 32-bit AXI4-Lite register bus and a 100 MHz system clock.
package wdt_pkg;
  // Register byte offsets
  localparam logic [3:0] WDT_OFS_CTRL = 4'h0;
  localparam logic [3:0] WDT_OFS_TACC = 4'h4;
  localparam logic [3:0] WDT_OFS_XIE = 4'h8;
  localparam logic [3:0] WDT_OFS_CNT = 4'hC;
  // Control/status field positions
  localparam int WDT_B_RESTART = 0;
  localparam int WDT_B_RSTEN = 1;
  localparam int WDT_B_CAUSE = 2;
  localparam int WDT_B_IRQF = 3;
  localparam int WDT_B_SELLO = 4;
  localparam int WDT_B_SELHI = 5;
  localparam int WDT_B_RUN = 7;
  localparam int WDT_B_XIE_WD = 4;
  // Reset values
  localparam logic [1:0] WDT_SEL_RST = 2'h0;
  localparam logic [7:0] WDT_XIE_RST = 8'h00;
  // Timed-access unlock keys and window
  localparam logic [7:0] WDT_KEY1 = 8'hAA;
  localparam logic [7:0] WDT_KEY2 = 8'h55;
  localparam int WDT_TA_WINDOW_CLKS = 64;
  // Timing counts in system clocks (WDT_SYSRST_MCS in machine cycles) and counter width
  localparam int WDT_POST_CLKS = 512;
  localparam int WDT_MC_CLKS = 4;
  localparam int WDT_SYSRST_MCS = 2;
  localparam int WDT_SYSRST_CLKS = WDT_SYSRST_MCS * WDT_MC_CLKS;
  localparam int WDT_CNT_W = 27;
  // AXI responses
  localparam logic [1:0] WDT_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDT_RESP_SLVERR = 2'h2;

  // Control/status register layout
  typedef struct packed {
    logic run;
    logic spare;
    logic [1:0] sel;
    logic irq_flag;
    logic cause;
    logic rst_en;
    logic restart;
  } wdt_ctrl_t;
endpackage : wdt_pkg

// ===== core/wdt_top.sv
// Watchdog timer unit: divider chain, time-out flag, delayed system reset,
// control register timed-access protected except for clearing the cause bit, AXI4-Lite slave.
// Assumes ARST_N is the power-on/power-fail reset and CE gates every update.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps

module wdt_top
  import wdt_pkg::*;
#(
  parameter int INTERVAL0_CLKS = 131072,
  parameter int INTERVAL1_CLKS = 1048576,
  parameter int INTERVAL2_CLKS = 8388608,
  parameter int INTERVAL3_CLKS = 67108864
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CE,
  // AXI4-Lite write address and data
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // System side
  input wire logic GLOBAL_IRQ_EN,
  output logic WDT_IRQ,
  output logic WDT_SYS_RST
);

  // Elaboration check on interval counts, every one must fit the counter
  localparam int CNT_SPAN = 1 << WDT_CNT_W;
  if (INTERVAL0_CLKS < 2 || INTERVAL1_CLKS < 2 || INTERVAL2_CLKS < 2 || INTERVAL3_CLKS < 2 ||
      INTERVAL0_CLKS > CNT_SPAN || INTERVAL1_CLKS > CNT_SPAN ||
      INTERVAL2_CLKS > CNT_SPAN || INTERVAL3_CLKS > CNT_SPAN) begin : g_bad_interval
    $error("wdt_top: interval counts out of range");
  end

  localparam logic [8:0] POST_LAST = 9'(WDT_POST_CLKS - 1);
  localparam logic [3:0] SYSRST_LEN = 4'(WDT_SYSRST_CLKS);
  localparam logic [6:0] TA_LEN = 7'(WDT_TA_WINDOW_CLKS);

  wdt_ctrl_t ctrl_q;
  logic [7:0] xie_q;
  logic [WDT_CNT_W-1:0] cnt_q;
  logic win_act_q;
  logic [8:0] win_cnt_q;
  logic [3:0] rst_cnt_q;
  logic key1_q;
  logic [6:0] unlock_cnt_q;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [WDT_CNT_W-1:0] last_cnt;
  logic tick, timeout, wd_fire, wr_fire, rd_fire, unlocked, lane0;
  logic wr_ctrl, wr_ctrl_ok, wr_tacc, wr_xie, wr_map;

  // Interval end value for a select code
  function automatic logic [WDT_CNT_W-1:0] last_of(input logic [1:0] sel);
    case (sel)
      2'h0: last_of = WDT_CNT_W'(INTERVAL0_CLKS - 1);
      2'h1: last_of = WDT_CNT_W'(INTERVAL1_CLKS - 1);
      2'h2: last_of = WDT_CNT_W'(INTERVAL2_CLKS - 1);
      default: last_of = WDT_CNT_W'(INTERVAL3_CLKS - 1);
    endcase
  endfunction : last_of

  // Bus write decode
  assign wr_fire = CE && aw_have_q && w_have_q && !bvalid_q;
  assign lane0 = w_strb_q[0];
  assign wr_map = (aw_addr_q == WDT_OFS_CTRL) || (aw_addr_q == WDT_OFS_TACC) ||
                  (aw_addr_q == WDT_OFS_XIE) || (aw_addr_q == WDT_OFS_CNT);
  assign wr_ctrl = wr_fire && lane0 && (aw_addr_q == WDT_OFS_CTRL);
  assign wr_tacc = wr_fire && lane0 && (aw_addr_q == WDT_OFS_TACC);
  assign wr_xie = wr_fire && lane0 && (aw_addr_q == WDT_OFS_XIE);
  assign unlocked = (unlock_cnt_q != 7'h00);
  assign wr_ctrl_ok = wr_ctrl && unlocked;

  // Divider chain events
  // run gates counting
  assign tick = CE && ctrl_q.run;
  assign last_cnt = last_of(ctrl_q.sel);
  assign timeout = tick && (cnt_q == last_cnt) && !ctrl_q.restart;
  assign wd_fire = tick && win_act_q && (win_cnt_q == POST_LAST) && ctrl_q.rst_en &&
                   !ctrl_q.restart;

  assign WDT_IRQ = ctrl_q.irq_flag && xie_q[WDT_B_XIE_WD] && GLOBAL_IRQ_EN;
  assign WDT_SYS_RST = (rst_cnt_q != 4'h0);

  // Free-running counter
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_q <= '0;
    end else if (CE) begin
      if (ctrl_q.restart || wd_fire) begin
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= (cnt_q >= last_cnt) ? '0 : cnt_q + 1'b1;
      end
    end
  end

  // Post time-out window of 512 clocks
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      win_act_q <= 1'b0;
      win_cnt_q <= '0;
    end else if (CE) begin
      if (ctrl_q.restart || wd_fire) begin
        win_act_q <= 1'b0;
        win_cnt_q <= '0;
      end else if (timeout && !win_act_q) begin
        win_act_q <= 1'b1;
        win_cnt_q <= '0;
      end else if (tick && win_act_q) begin
        win_act_q <= (win_cnt_q != POST_LAST);
        win_cnt_q <= win_cnt_q + 1'b1;
      end
    end
  end

  // System reset stretcher
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_cnt_q <= '0;
    end else if (CE) begin
      if (wd_fire) begin
        rst_cnt_q <= SYSRST_LEN;
      end else if (rst_cnt_q != 4'h0) begin
        rst_cnt_q <= rst_cnt_q - 1'b1;
      end
    end
  end

  // Control/status register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= '{run: 1'b0, spare: 1'b0, sel: WDT_SEL_RST, irq_flag: 1'b0,
                  cause: 1'b0, rst_en: 1'b0, restart: 1'b0};
    end else if (CE) begin
      ctrl_q.restart <= wr_ctrl_ok && w_data_q[WDT_B_RESTART];
      if (wr_ctrl_ok) begin
        ctrl_q.run <= w_data_q[WDT_B_RUN];
        ctrl_q.sel <= w_data_q[WDT_B_SELHI:WDT_B_SELLO];
        ctrl_q.rst_en <= w_data_q[WDT_B_RSTEN];
      end
      if (timeout) begin
        ctrl_q.irq_flag <= 1'b1;
      end else if (wd_fire) begin
        ctrl_q.irq_flag <= 1'b0;
      end else if (wr_ctrl_ok && !w_data_q[WDT_B_IRQF]) begin
        ctrl_q.irq_flag <= 1'b0;
      end
      if (wd_fire) begin
        ctrl_q.cause <= 1'b1;
      end else if (wr_ctrl && !w_data_q[WDT_B_CAUSE]) begin
        ctrl_q.cause <= 1'b0;
      end
    end
  end

  // Extended interrupt enable register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      xie_q <= WDT_XIE_RST;
    end else if (wr_xie) begin
      xie_q <= w_data_q[7:0];
    end
  end

  // Timed-access unlock sequencer
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      key1_q <= 1'b0;
      unlock_cnt_q <= '0;
    end else if (CE) begin
      if (wr_tacc) begin
        key1_q <= (w_data_q[7:0] == WDT_KEY1);
        unlock_cnt_q <= (key1_q && w_data_q[7:0] == WDT_KEY2) ? TA_LEN : 7'h00;
      end else if (wr_fire) begin
        key1_q <= 1'b0;
        unlock_cnt_q <= '0;
      end else if (unlocked) begin
        unlock_cnt_q <= unlock_cnt_q - 1'b1;
      end
    end
  end

  // Write address and data capture
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR[3:0];
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bvalid_q <= 1'b0;
      bresp_q <= WDT_RESP_OKAY;
    end else if (CE) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? WDT_RESP_OKAY : WDT_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel
  assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= WDT_RESP_OKAY;
    end else if (CE) begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q <= WDT_RESP_OKAY;
        case (S_AXI_ARADDR[3:0])
          WDT_OFS_CTRL: rdata_q <= {24'h000000, ctrl_q};
          WDT_OFS_TACC: rdata_q <= {31'h00000000, unlocked};
          WDT_OFS_XIE: rdata_q <= {24'h000000, xie_q};
          WDT_OFS_CNT: rdata_q <= {5'h00, cnt_q};
          default: begin
            rdata_q <= '0;
            rresp_q <= WDT_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Handshake outputs
  assign S_AXI_AWREADY = CE && !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY = CE && !w_have_q && !bvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = CE && !rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

endmodule : wdt_top

// ===== sim/wdt_top_props.sv
// Checker for the watchdog unit: bus handshakes and watchdog outputs.
// Assumes CE stays high while the bus and counters are watched.
`timescale 1ns/100ps
module wdt_top_props import wdt_pkg::*; (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Write channels
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  // Read channels
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  // System side
  input wire logic GLOBAL_IRQ_EN,
  input wire logic WDT_IRQ,
  input wire logic WDT_SYS_RST
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // Interrupt gating and reset pulse shape
  property p_irq_gate; WDT_IRQ |-> GLOBAL_IRQ_EN; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
  property p_rst_len; $rose(WDT_SYS_RST) |-> WDT_SYS_RST [*8] ##1 !WDT_SYS_RST; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
  property p_rst_irq; $rose(WDT_SYS_RST) |-> ##1 !WDT_IRQ; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq kept over reset");
  // Bus answers hold and come on time
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_time;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write answer late");
  property p_r_time; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_r_time: assert property (p_r_time) else $error("read answer late");
  property p_b_block; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken while answering");
  property p_r_block; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  a_r_block: assert property (p_r_block) else $error("read taken while answering");
  // Main scenarios reached
  c_rst: cover property ($rose(WDT_SYS_RST));
  c_irq: cover property ($rose(WDT_IRQ));
  c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule : wdt_top_props

bind wdt_top wdt_top_props u_props (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .WDT_IRQ(WDT_IRQ), .WDT_SYS_RST(WDT_SYS_RST));

// ===== sim/wdt_top_tb.sv
// Testbench for the watchdog unit: register access, intervals, reset path.
// Assumes short intervals set by parameters and CE held high.
`timescale 1ns/100ps
module wdt_top_tb import wdt_pkg::*;;
  // Intervals that do not divide the 512-clock window keep time-outs off the reset edge
  localparam int IV0 = 100;
  localparam logic [31:0] A_CNT = {28'h0, WDT_OFS_CNT};
  localparam logic [31:0] A_CTL = {28'h0, WDT_OFS_CTRL};
  localparam logic [31:0] A_KEY = {28'h0, WDT_OFS_TACC};
  localparam logic [31:0] A_XIE = {28'h0, WDT_OFS_XIE};
  logic clk, arst_n, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, gie, irq, srst, srst_q;
  logic [31:0] awa, wd, ara, rdat, rdv;
  logic [1:0] bp, rp, resp;
  int n_errors, check_count, n_rst, cyc, s;

  // System clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  wdt_top #(.INTERVAL0_CLKS(IV0), .INTERVAL1_CLKS(IV0 << 1), .INTERVAL2_CLKS(IV0 << 2),
    .INTERVAL3_CLKS(IV0 << 3)) dut (
    .CLK_SYS(clk), .ARST_N(arst_n), .CE(1'b1), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rp), .GLOBAL_IRQ_EN(gie),
    .WDT_IRQ(irq), .WDT_SYS_RST(srst));

  // Count system reset pulses
  always @(posedge clk) begin
    srst_q <= srst;
    if (srst && !srst_q) n_rst++;
  end

  // Expected interval for a select code
  function automatic int iv(input int k);
    return IV0 << k;
  endfunction : iv

  // Bus write, both channels offered together
  task automatic bw(input logic [31:0] a, input logic [31:0] d);
    logic da;
    logic dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!(da && dw)) begin
      @(posedge clk);
      da = da | awr;
      dw = dw | wrd;
      if (da) awv <= 1'b0;
      if (dw) wv <= 1'b0;
    end
    do @(posedge clk); while (!bv);
    resp = bp;
    br <= 1'b0;
  endtask : bw

  // Bus read
  task automatic brd(input logic [31:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rdv = rdat;
    resp = rp;
    rr <= 1'b0;
  endtask : brd

  // Unlocked write to a protected register
  task automatic uw(input logic [31:0] a, input logic [31:0] d);
    bw(A_KEY, {24'h0, WDT_KEY1});
    bw(A_KEY, {24'h0, WDT_KEY2});
    bw(a, d);
  endtask : uw

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic wait_irq;
    cyc = 0;
    while (irq !== 1'b1) begin
      @(posedge clk);
      cyc++;
    end
  endtask : wait_irq

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    {awv, wv, br, arv, rr, gie} = 6'h00;
    {awa, wd, ara} = 96'h0;
    arst_n = 1'b0;
    void'($urandom(55088));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    brd(A_CTL);
    chk(rdv, 32'h0);
    brd(32'h2);
    chk({30'h0, resp}, {30'h0, WDT_RESP_SLVERR});
    bw(32'h2, $urandom);
    chk({30'h0, resp}, {30'h0, WDT_RESP_SLVERR});
    $display("t1 end");
    for (s = 0; s < 6; s++) begin
      bw(A_CTL, $urandom);
      gie <= 1'($urandom);
      brd(A_CTL);
      chk(rdv, 32'h0);
    end
    $display("t2 end");
    bw(A_XIE, 32'h10);
    gie <= 1'b1;
    for (s = 0; s < 4; s++) begin
      uw(A_CTL, 32'h81 | 32'(s << 4));
      wait_irq();
      chk_rng(cyc, iv(s) - 3, iv(s) + 1);
      brd(A_CTL);
      chk(rdv, 32'h88 | 32'(s << 4));
    end
    chk(n_rst, 0);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    gie <= 1'b1;
    $display("t3 end");
    uw(A_CTL, 32'h83);
    wait_irq();
    cyc = 0;
    while (srst !== 1'b1) begin
      @(posedge clk);
      cyc++;
    end
    chk_rng(cyc, WDT_POST_CLKS - 2, WDT_POST_CLKS + 2);
    cyc = 0;
    while (srst === 1'b1) begin
      @(posedge clk);
      cyc++;
    end
    chk_rng(cyc, WDT_SYSRST_CLKS, WDT_SYSRST_CLKS);
    brd(A_CTL);
    chk(rdv, 32'h86);
    bw(A_CTL, 32'h0);
    brd(A_CTL);
    chk(rdv, 32'h82);
    $display("t4 end");
    wait_irq();
    uw(A_CTL, 32'h83);
    cyc = n_rst;
    // Span covers the old expiry but ends before the restarted one
    repeat (550) @(posedge clk);
    chk(n_rst, cyc);
    $display("t5 end");
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    brd(A_CTL);
    chk(rdv, 32'h0);
    brd(A_XIE);
    chk(rdv, 32'h0);
    // Stopped divider holds its count and flags nothing
    repeat (iv(0) + 50) @(posedge clk);
    brd(A_CNT);
    chk(rdv, 32'h0);
    brd(A_CTL);
    chk(rdv, 32'h0);
    // Interrupt and reset off, flag still polled
    uw(A_CTL, 32'h81);
    repeat (iv(0) + 5) @(posedge clk);
    brd(A_CTL);
    chk(rdv, 32'h88);
    chk({31'h0, irq}, 32'h0);
    chk(n_rst, cyc);
    $display("t6 end");
    close_out();
  end
endmodule : wdt_top_tb
